// ===== core/tra_pkg.sv
`default_nettype none

package tra_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] CONFIG_OFFSET    = 8'h00;
  localparam logic [7:0] RESOLUTION_OFFSET = 8'h04;
  localparam logic [7:0] LOCAL_OFFSET     = 8'h08;
  localparam logic [7:0] REMOTE_OFFSET    = 8'h0C;
  localparam logic [7:0] LOCAL_HI_OFFSET  = 8'h10;
  localparam logic [7:0] LOCAL_LO_OFFSET  = 8'h14;
  localparam logic [7:0] REMOTE_HI_OFFSET = 8'h18;
  localparam logic [7:0] REMOTE_LO_OFFSET = 8'h1C;
  localparam logic [7:0] LOCAL_TH_OFFSET  = 8'h20;
  localparam logic [7:0] REMOTE_TH_OFFSET = 8'h24;
  localparam logic [7:0] STATUS_OFFSET    = 8'h28;
  localparam logic [7:0] MASK_OFFSET      = 8'h2C;

  // Field positions.
  localparam int RANGE_BIT = 2;
  localparam int RES_LSB   = 0;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [1:0] RESOLUTION_RESET = 2'h3;
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'h55;
  localparam logic [7:0] LOW_LIMIT_RESET  = 8'h00;
  localparam logic [7:0] THERMAL_FLAG_OUT_RESET      = 8'h55;
  localparam logic [5:0] MASK_RESET       = 6'h00;
  localparam logic [7:0] RESULT_RESET     = 8'h00;
  localparam logic [5:0] STATUS_RESET     = 6'h00;

  // Encoding constants.
  localparam logic [7:0] STD_MAX_CODE = 8'h7F;
  localparam logic [7:0] STD_MIN_CODE = 8'h00;
  localparam logic [7:0] EXT_OFFSET   = 8'h40;
  localparam logic [7:0] EXT_MIN_CODE = 8'h00;
  localparam logic [7:0] EXT_MAX_CODE = 8'hFF;

  // Status bit positions.
  localparam int ST_LOCAL_HIGH   = 0;
  localparam int ST_LOCAL_LOW    = 1;
  localparam int ST_REMOTE_HIGH  = 2;
  localparam int ST_REMOTE_LOW   = 3;
  localparam int ST_LOCAL_THERMAL_FLAG_OUT  = 4;
  localparam int ST_REMOTE_THERMAL_FLAG_OUT = 5;

endpackage : tra_pkg

`default_nettype wire

// ===== core/tra_temp_result_format_alarm.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tra_temp_result_format_alarm (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        convValid,
  input  wire logic        convRemote,
  input  wire logic [12:0] convTemp,
  output logic             alarmOut,
  output logic             alarmOe,
  output logic             thermal_flag_out,
  output logic             thermalOe,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Formatting functions.
  // Conversion input is signed, in sixteenths of a degree: 9 integer bits
  // (-256..255) and 4 fraction bits.

  function automatic logic [7:0] fmt_high(input logic [12:0] t, input logic ext);
    logic signed [8:0] whole;
    logic signed [9:0] shifted;
    whole   = $signed(t[12:4]);
    shifted = 10'(whole) + 10'(tra_pkg::EXT_OFFSET);
    fmt_high = 8'h00;
    if (!ext) begin
      if (whole < 0) begin
        fmt_high = tra_pkg::STD_MIN_CODE;
      end else if (whole > 9'sd127) begin
        fmt_high = tra_pkg::STD_MAX_CODE;
      end else begin
        fmt_high = whole[7:0];
      end
    end else begin
      if (shifted < 0) begin
        fmt_high = tra_pkg::EXT_MIN_CODE;
      end else if (shifted > 10'sd255) begin
        fmt_high = tra_pkg::EXT_MAX_CODE;
      end else begin
        fmt_high = shifted[7:0];
      end
    end
  endfunction : fmt_high

  function automatic logic [7:0] fmt_low(input logic [12:0] t, input logic ext,
                                         input logic [1:0] res);
    logic [3:0] frac;
    logic [3:0] keep;
    logic signed [8:0] whole;
    whole = $signed(t[12:4]);
    frac  = t[3:0];
    case (res)
      2'h0:    keep = 4'h8;
      2'h1:    keep = 4'hC;
      2'h2:    keep = 4'hE;
      default: keep = 4'hF;
    endcase
    // Clamped values carry no fraction, so the pair reads as the limit itself.
    if (!ext && (whole < 0 || whole > 9'sd127)) begin
      frac = 4'h0;
    end else if (ext && (whole < -9'sd64 || whole > 9'sd191)) begin
      frac = 4'h0;
    end
    fmt_low = {frac & keep, 4'h0};
  endfunction : fmt_low

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0]  configQ, configD;
  logic [1:0]  resQ, resD;
  logic [7:0]  locHiQ, locHiD, locLoQ, locLoD;
  logic [7:0]  remHiQ, remHiD, remLoQ, remLoD;
  logic [7:0]  locHighLimQ, locHighLimD, locLowLimQ, locLowLimD;
  logic [7:0]  remHighLimQ, remHighLimD, remLowLimQ, remLowLimD;
  logic [7:0]  locThermQ, locThermD, remThermQ, remThermD;
  logic [5:0]  statusQ, statusD, maskQ, maskD;
  logic [31:0] prdataQ, prdataD;
  logic        preadyQ, preadyD, pslverrQ, pslverrD;
  logic        alarmQ, alarmD, thermQ, thermD, irqQ, irqD;
  logic [5:0]  events;
  logic        rangeExt;
  logic [7:0]  newHi, newLo;
  logic        access, wr, rd, hit;

  assign access = psel && penable && !preadyQ;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  // The range bit is sampled only when a conversion lands.
  assign rangeExt = configQ[tra_pkg::RANGE_BIT];
  assign newHi = fmt_high(convTemp, rangeExt);
  assign newLo = fmt_low(convTemp, rangeExt, convRemote ? 2'h3 : resQ);

  always_comb begin
    configD     = configQ;
    resD        = resQ;
    locHiD      = locHiQ;
    locLoD      = locLoQ;
    remHiD      = remHiQ;
    remLoD      = remLoQ;
    locHighLimD = locHighLimQ;
    locLowLimD  = locLowLimQ;
    remHighLimD = remHighLimQ;
    remLowLimD  = remLowLimQ;
    locThermD   = locThermQ;
    remThermD   = remThermQ;
    maskD       = maskQ;
    prdataD     = 32'h0000_0000;
    preadyD     = access;
    pslverrD    = 1'b0;
    hit         = 1'b1;
    if (convValid) begin
      if (convRemote) begin
        remHiD = newHi;
        remLoD = newLo;
      end else begin
        locHiD = newHi;
        locLoD = newLo;
      end
    end
    // Limit writes store the raw code; no re-encoding on range change.
    if (wr) begin
      if (paddr == tra_pkg::CONFIG_OFFSET) begin
        configD = pwdata[7:0];
      end else if (paddr == tra_pkg::RESOLUTION_OFFSET) begin
        resD = pwdata[tra_pkg::RES_LSB +: 2];
      end else if (paddr == tra_pkg::LOCAL_HI_OFFSET) begin
        locHighLimD = pwdata[7:0];
      end else if (paddr == tra_pkg::LOCAL_LO_OFFSET) begin
        locLowLimD = pwdata[7:0];
      end else if (paddr == tra_pkg::REMOTE_HI_OFFSET) begin
        remHighLimD = pwdata[7:0];
      end else if (paddr == tra_pkg::REMOTE_LO_OFFSET) begin
        remLowLimD = pwdata[7:0];
      end else if (paddr == tra_pkg::LOCAL_TH_OFFSET) begin
        locThermD = pwdata[7:0];
      end else if (paddr == tra_pkg::REMOTE_TH_OFFSET) begin
        remThermD = pwdata[7:0];
      end else if (paddr == tra_pkg::MASK_OFFSET) begin
        maskD = pwdata[5:0];
      end else if (paddr == tra_pkg::LOCAL_OFFSET || paddr == tra_pkg::REMOTE_OFFSET
                   || paddr == tra_pkg::STATUS_OFFSET) begin
        hit = 1'b1;
      end else begin
        hit = 1'b0;
      end
    end else if (rd) begin
      if (paddr == tra_pkg::CONFIG_OFFSET) begin
        prdataD = {24'h00_0000, configQ};
      end else if (paddr == tra_pkg::RESOLUTION_OFFSET) begin
        prdataD = {30'h0000_0000, resQ};
      end else if (paddr == tra_pkg::LOCAL_OFFSET) begin
        prdataD = {16'h0000, locHiQ, locLoQ};
      end else if (paddr == tra_pkg::REMOTE_OFFSET) begin
        prdataD = {16'h0000, remHiQ, remLoQ};
      end else if (paddr == tra_pkg::LOCAL_HI_OFFSET) begin
        prdataD = {24'h00_0000, locHighLimQ};
      end else if (paddr == tra_pkg::LOCAL_LO_OFFSET) begin
        prdataD = {24'h00_0000, locLowLimQ};
      end else if (paddr == tra_pkg::REMOTE_HI_OFFSET) begin
        prdataD = {24'h00_0000, remHighLimQ};
      end else if (paddr == tra_pkg::REMOTE_LO_OFFSET) begin
        prdataD = {24'h00_0000, remLowLimQ};
      end else if (paddr == tra_pkg::LOCAL_TH_OFFSET) begin
        prdataD = {24'h00_0000, locThermQ};
      end else if (paddr == tra_pkg::REMOTE_TH_OFFSET) begin
        prdataD = {24'h00_0000, remThermQ};
      end else if (paddr == tra_pkg::STATUS_OFFSET) begin
        prdataD = {26'h000_0000, statusQ};
      end else if (paddr == tra_pkg::MASK_OFFSET) begin
        prdataD = {26'h000_0000, maskQ};
      end else begin
        hit = 1'b0;
      end
    end
    pslverrD = access && !hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm evaluation on the stored codes, in whichever range is current.

  always_comb begin
    events = 6'h00;
    events[tra_pkg::ST_LOCAL_HIGH]   = locHiQ > locHighLimQ;
    events[tra_pkg::ST_LOCAL_LOW]    = locHiQ < locLowLimQ;
    events[tra_pkg::ST_REMOTE_HIGH]  = remHiQ > remHighLimQ;
    events[tra_pkg::ST_REMOTE_LOW]   = remHiQ < remLowLimQ;
    events[tra_pkg::ST_LOCAL_THERMAL_FLAG_OUT]  = locHiQ > locThermQ;
    events[tra_pkg::ST_REMOTE_THERMAL_FLAG_OUT] = remHiQ > remThermQ;
    // A set in the same cycle as the clearing read survives.
    statusD = ((rd && paddr == tra_pkg::STATUS_OFFSET) ? 6'h00 : statusQ) | events;
    alarmD  = |events[3:0];
    thermD  = |events[5:4];
    irqD    = |(statusD & ~maskQ);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      configQ     <= tra_pkg::CONFIG_RESET;
      resQ        <= tra_pkg::RESOLUTION_RESET;
      locHiQ      <= tra_pkg::RESULT_RESET;
      locLoQ      <= tra_pkg::RESULT_RESET;
      remHiQ      <= tra_pkg::RESULT_RESET;
      remLoQ      <= tra_pkg::RESULT_RESET;
      locHighLimQ <= tra_pkg::HIGH_LIMIT_RESET;
      locLowLimQ  <= tra_pkg::LOW_LIMIT_RESET;
      remHighLimQ <= tra_pkg::HIGH_LIMIT_RESET;
      remLowLimQ  <= tra_pkg::LOW_LIMIT_RESET;
      locThermQ   <= tra_pkg::THERMAL_FLAG_OUT_RESET;
      remThermQ   <= tra_pkg::THERMAL_FLAG_OUT_RESET;
      statusQ     <= tra_pkg::STATUS_RESET;
      maskQ       <= tra_pkg::MASK_RESET;
      prdataQ     <= 32'h0000_0000;
      preadyQ     <= 1'b0;
      pslverrQ    <= 1'b0;
      alarmQ      <= 1'b0;
      thermQ      <= 1'b0;
      irqQ        <= 1'b0;
    end else begin
      configQ     <= configD;
      resQ        <= resD;
      locHiQ      <= locHiD;
      locLoQ      <= locLoD;
      remHiQ      <= remHiD;
      remLoQ      <= remLoD;
      locHighLimQ <= locHighLimD;
      locLowLimQ  <= locLowLimD;
      remHighLimQ <= remHighLimD;
      remLowLimQ  <= remLowLimD;
      locThermQ   <= locThermD;
      remThermQ   <= remThermD;
      statusQ     <= statusD;
      maskQ       <= maskD;
      prdataQ     <= prdataD;
      preadyQ     <= preadyD;
      pslverrQ    <= pslverrD;
      alarmQ      <= alarmD;
      thermQ      <= thermD;
      irqQ        <= irqD;
    end
  end

  // Open-drain pins: the data output is held low; only the enable moves.
  assign alarmOut         = 1'b0;
  assign thermal_flag_out = 1'b0;
  assign alarmOe          = alarmQ;
  assign thermalOe        = thermQ;
  assign prdata           = prdataQ;
  assign pready           = preadyQ;
  assign pslverr          = pslverrQ;
  assign irq              = irqQ;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_std_clamp_low: assert property (@(posedge clock) disable iff (rst)
    convValid && !convRemote && !rangeExt && convTemp[12]
    |=> locHiQ == 8'h00)
    else $error("standard range negative not clamped");
  chk_std_clamp_high: assert property (@(posedge clock) disable iff (rst)
    convValid && convRemote && !rangeExt && !convTemp[12] && convTemp[11]
    |=> remHiQ == 8'h7F)
    else $error("standard range high not saturated");
  chk_ext_offset: assert property (@(posedge clock) disable iff (rst)
    convValid && convRemote && rangeExt && convTemp[12:4] == 9'h000
    |=> remHiQ == 8'h40)
    else $error("extended zero not 40h");
  chk_range_hold: assert property (@(posedge clock) disable iff (rst)
    !convValid |=> $stable(locHiQ) && $stable(remHiQ))
    else $error("result changed without conversion");
  chk_remote_frac: assert property (@(posedge clock) disable iff (rst)
    convValid && convRemote && !convTemp[12] && !convTemp[11] && !rangeExt
    |=> remLoQ == {$past(convTemp[3:0]), 4'h0})
    else $error("remote fraction wrong");
  chk_half_res: assert property (@(posedge clock) disable iff (rst)
    convValid && !convRemote && resQ == 2'h0 |=> locLoQ[6:0] == 7'h00)
    else $error("half degree resolution leaked bits");
  chk_low_nibble: assert property (@(posedge clock) disable iff (rst)
    locLoQ[3:0] == 4'h0 && remLoQ[3:0] == 4'h0)
    else $error("low nibble nonzero");
  chk_alarm_high: assert property (@(posedge clock) disable iff (rst)
    locHiQ > locHighLimQ |=> alarmOe)
    else $error("limit alarm missing");
  chk_thermal_flag_out_flag: assert property (@(posedge clock) disable iff (rst)
    remHiQ > remThermQ |=> thermalOe)
    else $error("thermal flag missing");
  chk_pin_low: assert property (@(posedge clock) disable iff (rst)
    !alarmOut && !thermal_flag_out)
    else $error("open-drain pin driven high");
  chk_limit_kept: assert property (@(posedge clock) disable iff (rst)
    !(wr && paddr == tra_pkg::LOCAL_HI_OFFSET) |=> $stable(locHighLimQ))
    else $error("limit changed without write");

  // Alarm enables follow the stored codes one edge late, so each check looks one edge ahead.
  chk_alarm_low: assert property (@(posedge clock) disable iff (rst)
    locHiQ < locLowLimQ || remHiQ < remLowLimQ |=> alarmOe)
    else $error("low limit alarm missing");
  chk_alarm_remote: assert property (@(posedge clock) disable iff (rst)
    remHiQ > remHighLimQ |=> alarmOe)
    else $error("remote limit alarm missing");
  // The alarm is a comparator level, not a latch: it must drop once every code is in band.
  chk_alarm_idle: assert property (@(posedge clock) disable iff (rst)
    locHiQ <= locHighLimQ && locHiQ >= locLowLimQ
    && remHiQ <= remHighLimQ && remHiQ >= remLowLimQ |=> !alarmOe)
    else $error("limit alarm without crossing");
  chk_thermal_flag_out_local: assert property (@(posedge clock) disable iff (rst)
    locHiQ > locThermQ |=> thermalOe)
    else $error("local thermal flag missing");
  chk_thermal_flag_out_idle: assert property (@(posedge clock) disable iff (rst)
    locHiQ <= locThermQ && remHiQ <= remThermQ |=> !thermalOe)
    else $error("thermal flag without crossing");
  chk_ext_floor: assert property (@(posedge clock) disable iff (rst)
    convValid && convRemote && rangeExt && convTemp[12] && convTemp[11:4] < 8'hC0
    |=> remHiQ == tra_pkg::EXT_MIN_CODE)
    else $error("extended range floor not 00h");
  chk_ext_top: assert property (@(posedge clock) disable iff (rst)
    convValid && !convRemote && rangeExt && !convTemp[12] && convTemp[11:4] > 8'hBF
    |=> locHiQ == tra_pkg::EXT_MAX_CODE)
    else $error("extended range top not FFh");
  chk_std_whole: assert property (@(posedge clock) disable iff (rst)
    convValid && convRemote && !rangeExt && convTemp[12:11] == 2'h0
    |=> remHiQ == {1'h0, $past(convTemp[10:4])})
    else $error("standard whole degrees wrong");
  chk_quarter_res: assert property (@(posedge clock) disable iff (rst)
    convValid && !convRemote && resQ == 2'h1 |=> locLoQ[5:0] == 6'h00)
    else $error("quarter degree resolution leaked bits");
  chk_limit_range: assert property (@(posedge clock) disable iff (rst)
    wr && paddr == tra_pkg::CONFIG_OFFSET |=> $stable(remHighLimQ) && $stable(remLowLimQ))
    else $error("range change moved a limit");
  // Set wins over the clearing read, so an event in the read cycle is never lost.
  chk_status_set: assert property (@(posedge clock) disable iff (rst)
    events != 6'h00 |=> (statusQ & $past(events)) == $past(events))
    else $error("status event lost");
  chk_ready_pulse: assert property (@(posedge clock) disable iff (rst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  cov_ext_conv: cover property (@(posedge clock) convValid && rangeExt);
  cov_alarm:    cover property (@(posedge clock) $rose(alarmOe));
  cov_thermal_flag_out:    cover property (@(posedge clock) $rose(thermalOe));
  cov_irq:      cover property (@(posedge clock) $rose(irq));
  cov_clamp:    cover property (@(posedge clock) convValid && !rangeExt && convTemp[12]);

endmodule : tra_temp_result_format_alarm

`default_nettype wire

// ===== verification/tra_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module tra_board_model (
  input  wire logic        clock,
  input  wire logic        alarmOut,
  input  wire logic        alarmOe,
  input  wire logic        thermalOut,
  input  wire logic        thermalOe,
  output logic             convValid,
  output logic             convRemote,
  output logic [12:0]      convTemp,
  output logic             alarmPin,
  output logic             thermalPin
);
  // Board pull-ups hold both pins high unless the device sinks them.
  assign alarmPin   = alarmOe ? alarmOut : 1'b1;
  assign thermalPin = thermalOe ? thermalOut : 1'b1;
  initial begin
    convValid  = 1'b0;
    convRemote = 1'b0;
    convTemp   = 13'h0000;
  end
  task automatic convert(input logic remote, input logic [12:0] temp);
    @(posedge clock);
    convValid  <= 1'b1;
    convRemote <= remote;
    convTemp   <= temp;
    @(posedge clock);
    convValid  <= 1'b0;
    // Released qualifiers are inverted so nothing can lean on stale values.
    convRemote <= ~remote;
    convTemp   <= ~temp;
  endtask : convert
endmodule : tra_board_model
`default_nettype wire

// ===== verification/tra_temp_result_format_alarm_test.sv
`timescale 1ns/1ps
`default_nettype none
module tra_temp_result_format_alarm_test;
  logic        clock;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, convValid, convRemote, irq;
  logic [12:0] convTemp;
  logic        alarmOut, alarmOe, thermalOut, thermalOe, alarmPin, thermalPin;
  logic [7:0]  lim [6];
  logic [7:0]  hiL = 8'h00;
  logic [7:0]  hiR = 8'h00;
  logic        curExt;
  logic [1:0]  curRes;
  logic [31:0] q;
  logic        e;
  logic [12:0] corner [8] = '{13'h1FF0, 13'h0800, 13'h07FF, 13'h0000,
                              13'h1C00, 13'h1BF0, 13'h0BF0, 13'h0C00};
  int          compares = 0;
  int          miscompares = 0;
  tra_temp_result_format_alarm dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convValid(convValid), .convRemote(convRemote), .convTemp(convTemp),
    .alarmOut(alarmOut), .alarmOe(alarmOe), .thermal_flag_out(thermalOut),
    .thermalOe(thermalOe), .irq(irq));
  tra_board_model board_u (.clock(clock), .alarmOut(alarmOut), .alarmOe(alarmOe),
    .thermalOut(thermalOut), .thermalOe(thermalOe), .convValid(convValid),
    .convRemote(convRemote), .convTemp(convTemp), .alarmPin(alarmPin), .thermalPin(thermalPin));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setMode(input logic ext, input logic [1:0] res);
    curExt = ext;
    curRes = res;
    apb(1'b1, tra_pkg::CONFIG_OFFSET, {29'h0, ext, 2'h0});
    apb(1'b1, tra_pkg::RESOLUTION_OFFSET, {30'h0, res});
  endtask : setMode
  // Whole degrees are clamped to the range's span; clamped results carry no fraction.
  function automatic logic [15:0] expRes(logic [12:0] t, logic ext, logic rem, logic [1:0] res);
    int w;
    logic [7:0] m;
    w = int'($signed(t[12:4])) + (ext ? 64 : 0);
    if (w < 0) return 16'h0000;
    if (w > (ext ? 255 : 127)) return {(ext ? 8'hFF : 8'h7F), 8'h00};
    m = rem ? 8'hF0 : 8'(8'hF0 << (2'h3 - res));
    return {8'(w), {t[3:0], 4'h0} & m};
  endfunction : expRes
  task automatic convChk(input logic rem, input logic [12:0] t);
    logic [15:0] r;
    r = expRes(t, curExt, rem, curRes);
    board_u.convert(rem, t);
    if (rem) hiR = r[15:8];
    else hiL = r[15:8];
    apb(1'b0, rem ? tra_pkg::REMOTE_OFFSET : tra_pkg::LOCAL_OFFSET, 32'h0);
    chk("result", {16'h0, r}, q);
    chk("alarm pin", {31'h0, ~((hiL > lim[0]) | (hiL < lim[1]) | (hiR > lim[2])
        | (hiR < lim[3]))}, {31'h0, alarmPin});
    chk("thermal pin", {31'h0, ~((hiL > lim[4]) | (hiR > lim[5]))}, {31'h0, thermalPin});
  endtask : convChk
  task automatic setLim(input int j, input logic [7:0] v);
    lim[j] = v;
    apb(1'b1, tra_pkg::LOCAL_HI_OFFSET + 8'(4 * j), {24'h0, v});
  endtask : setLim
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(77));
    lim = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, tra_pkg::CONFIG_OFFSET, 32'h0);
    chk("config", 32'h0, q);
    apb(1'b0, tra_pkg::RESOLUTION_OFFSET, 32'h0);
    chk("resolution", 32'h3, q);
    for (int j = 0; j < 6; j++) begin
      apb(1'b0, tra_pkg::LOCAL_HI_OFFSET + 8'(4 * j), 32'h0);
      chk("limit", {24'h0, lim[j]}, q);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e}); // pslverr on an unmapped read
    chk("unmapped data", 32'h0, q);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
    setMode(1'b0, 2'h3);
    convChk(1'b0, 13'h0190);
    setLim(0, 8'h30);
    apb(1'b1, tra_pkg::CONFIG_OFFSET, 32'h4);
    curExt = 1'b1;
    apb(1'b0, tra_pkg::LOCAL_OFFSET, 32'h0);
    chk("held result", 32'h1900, q);
    apb(1'b1, tra_pkg::LOCAL_OFFSET, 32'hFFFF);
    apb(1'b0, tra_pkg::LOCAL_HI_OFFSET, 32'h0);
    chk("limit kept", 32'h30, q);
    convChk(1'b0, 13'h0190);
    convChk(1'b1, 13'h0008);
    $display("test range change done");
    for (int k = 0; k < 8; k++) begin
      setMode(k >= 4, 2'(k));
      convChk(1'(k), corner[k]);
    end
    $display("test corners done");
    for (int i = 0; i < 30; i++) begin
      setMode(1'($urandom), 2'($urandom));
      for (int j = 0; j < 6; j++) setLim(j, 8'($urandom));
      convChk(1'($urandom), 13'($urandom));
    end
    $display("test random done");
    setMode(1'b0, 2'h3);
    for (int j = 0; j < 6; j++) setLim(j, (j % 2) ? 8'h00 : 8'hFF);
    convChk(1'b0, 13'h0000);
    convChk(1'b1, 13'h0000);
    apb(1'b0, tra_pkg::STATUS_OFFSET, 32'h0);
    apb(1'b0, tra_pkg::STATUS_OFFSET, 32'h0);
    chk("status clear", 32'h0, q);
    setLim(0, 8'h55);
    setLim(4, 8'h55);
    convChk(1'b0, 13'h0640);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, tra_pkg::MASK_OFFSET, 32'h01);
    @(posedge clock);
    chk("irq one masked", 32'h1, {31'h0, irq});
    apb(1'b1, tra_pkg::MASK_OFFSET, 32'h11);
    @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, tra_pkg::STATUS_OFFSET, 32'h0);
    chk("status", 32'h11, q);
    apb(1'b1, tra_pkg::MASK_OFFSET, 32'h00);
    convChk(1'b0, 13'h01E0);
    apb(1'b0, tra_pkg::STATUS_OFFSET, 32'h0);
    apb(1'b0, tra_pkg::STATUS_OFFSET, 32'h0);
    chk("status read clear", 32'h0, q);
    @(posedge clock);
    chk("irq low", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : tra_temp_result_format_alarm_test
`default_nettype wire
